// *** logic/serial_port_map.vh ***
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
// control port byte and reset watchdog
`define BYTE_BITS 8
`define RESET_SHIFT_CYCLES 16
// slot position field width and its reset value
`define SLOT_WIDTH 8
`define SLOT_RESET 8'h00
// master clock range, kHz
`define MCLK_MIN_KHZ 512
`define MCLK_MAX_KHZ 8192
// bit clock below this rate adds one frame of voice latency, kHz
`define SLOW_PCLK_KHZ 1536
// system clock period, ns
`define SYS_CLK_NS 10
// command bytes handled by this port
`define CMD_SET_SLOT 8'h40
`define CMD_READ_SLOT 8'h41
`define CMD_CLK_SEL 8'h46
`define CMD_READ_CLK 8'h47
// clock config bit positions
`define CFG_SRC_BIT 7
`define CFG_SLOW_BIT 6
`define CFG_RESET 8'h00
`endif

// *** logic/stream_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock, // system clock
  input wire nrst, // async reset, active low
  input wire in_valid, // write request
  output wire in_ready, // not full
  input wire [WIDTH-1:0] in_data, // write data
  output wire out_valid, // not empty
  input wire out_ready, // read accept
  output wire [WIDTH-1:0] out_data // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire push;
  wire pop;
  assign in_ready = (wr_q - rd_q) != DEPTH[AW:0];
  assign out_valid = wr_q != rd_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q[AW-1:0]];
  always @(posedge clock) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/host_serial_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module host_serial_port #(
  parameter SLOT_W = `SLOT_WIDTH,
  parameter FIFO_DEPTH = 8
) (
  input wire clock, // system clock, 100 MHz
  input wire nrst, // async reset, active low
  input wire select_n, // control port select pin
  input wire control_shift_clock, // control port shift clock pin
  input wire serial_in, // control port data in pin
  output reg serial_out, // control port data out
  output reg serial_oe, // high while driving data out
  input wire pcm_bit_clock, // pcm highway bit clock pin
  input wire frame_sync, // pcm frame sync pin
  input wire master_clock_in, // dedicated master clock pin
  output wire master_clock, // selected master clock
  output wire slot_strobe_n_o, // open drain level, always low
  output reg slot_strobe_n_oe, // high while pulling strobe low
  output wire extra_frame_delay, // slow bit clock latency flag
  output reg device_reset, // one-cycle internal reset pulse
  output wire [7:0] cmd_data, // command byte from fifo
  output wire cmd_valid, // command waiting
  input wire cmd_ready // consumer takes command
);
  //////////////////////////////////////////////////////////////////////
  // synchronisers, two flops before use
  reg [1:0] cs_s;
  reg [1:0] sck_s;
  reg [1:0] sdi_s;
  reg [1:0] pclk_s;
  reg [1:0] fs_s;
  reg cs_q;
  reg sck_q;
  reg pclk_q;
  reg fs_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      sdi_s <= 2'h0;
      pclk_s <= 2'h0;
      fs_s <= 2'h0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      pclk_q <= 1'b0;
      fs_q <= 1'b0;
    end else begin
      cs_s <= {cs_s[0], select_n};
      sck_s <= {sck_s[0], control_shift_clock};
      sdi_s <= {sdi_s[0], serial_in};
      pclk_s <= {pclk_s[0], pcm_bit_clock};
      fs_s <= {fs_s[0], frame_sync};
      cs_q <= cs_s[1];
      sck_q <= sck_s[1];
      pclk_q <= pclk_s[1];
      fs_q <= fs_s[1];
    end
  end
  wire cs_low = !cs_s[1];
  wire cs_fall = cs_q && !cs_s[1];
  wire cs_rise = !cs_q && cs_s[1];
  wire sck_rise = !sck_q && sck_s[1];
  wire sck_fall = sck_q && !sck_s[1];
  wire pclk_rise = !pclk_q && pclk_s[1];
  wire fs_rise = !fs_q && fs_s[1];

  //////////////////////////////////////////////////////////////////////
  // control port shifter
  reg [7:0] shift_q;
  reg [2:0] bitcnt_q;
  reg [4:0] cyc_q;
  reg [7:0] last_q;
  reg have_byte_q;
  reg [7:0] tx_q;
  reg read_pend_q;
  reg [SLOT_W-1:0] slot_q;
  reg [7:0] cfg_q;
  reg arg_slot_q;
  reg arg_cfg_q;
  wire [7:0] shift_next = {shift_q[6:0], sdi_s[1]};
  wire byte_done = cs_low && sck_rise && bitcnt_q == 3'h7;
  wire fifo_in_ready;
  // command codes are consumed here and never reach the fifo
  function is_command;
    input [7:0] b;
    begin
      is_command = b == `CMD_SET_SLOT || b == `CMD_READ_SLOT || b == `CMD_CLK_SEL || b == `CMD_READ_CLK;
    end
  endfunction
  // dummy bytes of a read frame and argument bytes are not commands for the fifo
  wire byte_plain = have_byte_q && !read_pend_q && !arg_slot_q && !arg_cfg_q && !is_command(last_q);
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shift_q <= 8'h00;
      bitcnt_q <= 3'h0;
      cyc_q <= 5'h00;
      last_q <= 8'h00;
      have_byte_q <= 1'b0;
      tx_q <= 8'h00;
      read_pend_q <= 1'b0;
      slot_q <= `SLOT_RESET;
      cfg_q <= `CFG_RESET;
      arg_slot_q <= 1'b0;
      arg_cfg_q <= 1'b0;
      serial_out <= 1'b0;
      serial_oe <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      device_reset <= 1'b0;
      if (cs_low && sck_rise && cyc_q == `RESET_SHIFT_CYCLES - 1) begin
        device_reset <= 1'b1;
        slot_q <= `SLOT_RESET;
        cfg_q <= `CFG_RESET;
        bitcnt_q <= 3'h0;
        have_byte_q <= 1'b0;
        arg_slot_q <= 1'b0;
        arg_cfg_q <= 1'b0;
        read_pend_q <= 1'b0;
        cyc_q <= 5'h00;
      end else if (cs_low) begin
        if (sck_rise) begin
          shift_q <= shift_next;
          bitcnt_q <= bitcnt_q + 3'h1;
          cyc_q <= cyc_q + 5'h01;
          if (byte_done) begin
            last_q <= shift_next;
            have_byte_q <= 1'b1;
          end
        end
        if (read_pend_q && ((cs_fall && !sck_s[1]) || sck_fall)) begin
          serial_oe <= 1'b1;
          serial_out <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
      if (cs_fall) begin
        bitcnt_q <= 3'h0;
        cyc_q <= 5'h00;
        have_byte_q <= 1'b0;
      end
      // act on last byte at release
      if (cs_rise) begin
        serial_oe <= 1'b0;
        read_pend_q <= 1'b0;
        if (have_byte_q && !read_pend_q) begin
          arg_slot_q <= 1'b0;
          arg_cfg_q <= 1'b0;
          if (arg_slot_q) begin
            slot_q <= last_q[SLOT_W-1:0];
          end else if (arg_cfg_q) begin
            cfg_q <= last_q;
          end else if (last_q == `CMD_SET_SLOT) begin
            arg_slot_q <= 1'b1;
          end else if (last_q == `CMD_CLK_SEL) begin
            arg_cfg_q <= 1'b1;
          end else if (last_q == `CMD_READ_SLOT) begin
            tx_q <= slot_q;
            read_pend_q <= 1'b1;
          end else if (last_q == `CMD_READ_CLK) begin
            tx_q <= cfg_q;
            read_pend_q <= 1'b1;
          end
        end
      end
    end
  end
  // other bytes go to the command fifo; a full fifo drops them
  stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) cmd_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(cs_rise && byte_plain && fifo_in_ready),
    .in_ready(fifo_in_ready),
    .in_data(last_q),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_data)
  );

  //////////////////////////////////////////////////////////////////////
  // pcm slot strobe
  reg [SLOT_W:0] slot_cnt_q;
  reg counting_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slot_cnt_q <= {(SLOT_W+1){1'b0}};
      counting_q <= 1'b0;
      slot_strobe_n_oe <= 1'b0;
    end else if (fs_rise) begin
      slot_cnt_q <= {(SLOT_W+1){1'b0}};
      counting_q <= 1'b1;
      slot_strobe_n_oe <= 1'b0;
    end else if (counting_q && pclk_rise) begin
      slot_cnt_q <= slot_cnt_q + 1'b1;
      slot_strobe_n_oe <= slot_cnt_q == {1'b0, slot_q};
      if (slot_cnt_q == {1'b0, slot_q}) begin
        counting_q <= 1'b0;
      end
    end else if (!counting_q && pclk_rise) begin
      slot_strobe_n_oe <= 1'b0;
    end
  end
  assign slot_strobe_n_o = 1'b0;

  //////////////////////////////////////////////////////////////////////
  // master clock source
  // source select from config
  assign master_clock = cfg_q[`CFG_SRC_BIT] ? pclk_s[1] : master_clock_in;
  assign extra_frame_delay = cfg_q[`CFG_SLOW_BIT];
endmodule
`default_nettype wire

// *** dv/host_serial_port_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_assertions (
  input wire clock, // clk
  input wire nrst, // rst
  input wire select_n, // sel
  input wire control_shift_clock, // sclk
  input wire serial_out, // dout
  input wire serial_oe, // dout en
  input wire pcm_bit_clock, // bclk
  input wire master_clock_in, // mclk pin
  input wire master_clock, // mclk
  input wire slot_strobe_n_o, // strobe
  input wire slot_strobe_n_oe, // strobe en
  input wire extra_frame_delay, // slow
  input wire device_reset, // rst pulse
  input wire [7:0] cmd_data, // head
  input wire cmd_valid, // valid
  input wire cmd_ready // ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence slot_held; slot_strobe_n_oe [*8]; endsequence
  sequence slot_gone; !slot_strobe_n_oe; endsequence
  oe_release_a: assert property ($rose(select_n) |-> ##6 !serial_oe)
    else $error("read drive outlives select");
  reset_pulse_a: assert property (device_reset |=> !device_reset)
    else $error("reset pulse too long");
  reset_clear_a: assert property (device_reset |-> ##[1:3] !extra_frame_delay)
    else $error("config kept over reset");
  strobe_width_a: assert property ($rose(slot_strobe_n_oe) |-> slot_held ##[1:12] slot_gone)
    else $error("strobe width wrong");
  strobe_low_a: assert property (!slot_strobe_n_o)
    else $error("strobe drives high");
  // bit clock path passes two sync flops; the check also allows three
  mclk_source_a: assert property (master_clock != master_clock_in |->
    master_clock == $past(pcm_bit_clock, 2) || master_clock == $past(pcm_bit_clock, 3))
    else $error("master clock from neither source");
  out_edge_a: assert property (serial_oe && $past(serial_oe) && $changed(serial_out)
    |-> !control_shift_clock)
    else $error("read bit moved on rising edge");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command lost while stalled");
endmodule
bind host_serial_port host_serial_port_assertions u_chk (.clock, .nrst, .select_n,
  .control_shift_clock, .serial_out, .serial_oe, .pcm_bit_clock, .master_clock_in,
  .master_clock, .slot_strobe_n_o, .slot_strobe_n_oe, .extra_frame_delay, .device_reset,
  .cmd_data, .cmd_valid, .cmd_ready);
`default_nettype wire

// *** dv/pcm_backplane_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcm_backplane_model (
  output logic pcm_bit_clock, // bclk
  output logic frame_sync, // sync
  output logic master_clock_in // mclk
);
  int n = 0;
  // 6.25 MHz bit clock, offset from the system clock
  initial begin
    pcm_bit_clock = 1'b0;
    frame_sync = 1'b0;
    #13;
    forever #80 pcm_bit_clock = ~pcm_bit_clock;
  end
  // separate master clock locked to the bit clock
  assign master_clock_in = ~pcm_bit_clock;
  // frame of 32 bit clocks, changed on the falling edge
  always @(negedge pcm_bit_clock) begin
    n <= (n + 1) % 32;
    frame_sync <= (n == 0);
  end
endmodule
`default_nettype wire

// *** dv/host_serial_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic select_n = 1'b1;
  logic control_shift_clock = 1'b0;
  logic serial_in = 1'b0;
  logic cmd_ready = 1'b0;
  logic hold = 1'b1;
  logic fs_q = 1'b0;
  logic pc_q = 1'b0;
  logic line_q = 1'b1;
  logic [7:0] r, b;
  logic [7:0] q[$];
  logic [31:0] rs = 32'd76;
  wire serial_out, serial_oe, pcm_bit_clock, frame_sync, master_clock_in, master_clock;
  wire slot_strobe_n_o, slot_strobe_n_oe, extra_frame_delay, device_reset, cmd_valid;
  wire [7:0] cmd_data;
  // pull-up holds the strobe line high whenever the device lets go
  wire slot_line = slot_strobe_n_oe ? slot_strobe_n_o : 1'b1;
  // a released data pin reads inverted so a missing enable shows up
  wire sdo_line = serial_oe ? serial_out : !serial_out;
  int fails = 0;
  int n_checks = 0;
  int k, bits, seen;
  always #5 clock = ~clock;
  host_serial_port u_host_serial_port (.clock, .nrst, .select_n, .control_shift_clock,
    .serial_in, .serial_out, .serial_oe, .pcm_bit_clock, .frame_sync, .master_clock_in,
    .master_clock, .slot_strobe_n_o, .slot_strobe_n_oe, .extra_frame_delay, .device_reset,
    .cmd_data, .cmd_valid, .cmd_ready);
  pcm_backplane_model u_pcm_backplane_model (.pcm_bit_clock, .frame_sync, .master_clock_in);
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one select frame of n shift clocks, msb first; read bits gather in r
  task automatic xfer(input logic [7:0] v, input int n);
    @(posedge clock) select_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in <= v[7 - i % 8];
      // shift clock parked long in both levels mid byte
      repeat (i == 4 ? 60 : 8) @(posedge clock);
      control_shift_clock <= 1'b1;
      r = {r[6:0], sdo_line};
      repeat (i == 4 ? 60 : 8) @(posedge clock);
      control_shift_clock <= 1'b0;
    end
    repeat (8) @(posedge clock);
    select_n <= 1'b1;
    // gap scaled for 6.25 MHz; master clock never stops
    repeat (270) @(posedge clock);
  endtask
  // counts samples where master clock equals the raw bit clock over one bit period
  task automatic mclk_match(input logic [7:0] exp);
    int m;
    m = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      m += (master_clock === pcm_bit_clock);
    end
    check(8'(m), exp);
  endtask
  always @(posedge clock) begin
    fs_q <= frame_sync;
    pc_q <= pcm_bit_clock;
    line_q <= slot_line;
    if (frame_sync && !fs_q)
      bits <= 0;
    else if (pcm_bit_clock && !pc_q)
      bits <= bits + 1;
    // strobe seen on the pulled-up line
    if (!slot_line && line_q)
      seen <= bits;
    cmd_ready <= !hold && rnd() % 2;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      check(cmd_data, q.size() ? q.pop_front() : 8'hxx);
  end
  initial begin
    #900000;
    fails++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    for (k = 0; k < 9; k++) begin
      b = 8'(rnd() % 64);
      if (k < 8)
        q.push_back(b);
      xfer(b, 8);
    end
    hold <= 1'b0;
    repeat (200) @(posedge clock);
    check(8'(q.size()), 8'h00);
    $display("test stream done");
    k = rnd() % 7 + 1;
    xfer(8'h40, 8);
    xfer(8'(k), 8);
    xfer(8'h41, 8);
    xfer(8'h00, 8);
    check(r, 8'(k));
    check(8'(seen), 8'(k + 1));
    $display("test slot done");
    xfer(8'h46, 8);
    xfer(8'hc0, 8);
    xfer(8'h47, 8);
    xfer(8'h00, 8);
    check(r, 8'hc0);
    check({7'h00, extra_frame_delay}, 8'h01);
    mclk_match(8'h0c);
    $display("test clock done");
    xfer(8'h46, 16);
    check({7'h00, extra_frame_delay}, 8'h00);
    xfer(8'h41, 8);
    xfer(8'h00, 8);
    check(r, 8'h00);
    check(8'(seen), 8'h01);
    mclk_match(8'h00);
    $display("test reset done");
    close_out;
  end
endmodule
`default_nettype wire
